// ---- hdl/low_power_logger_sequencer.sv ----
// mode sequencer of the low-power data logger: standby, snooze sampling and escalation to transmit
`timescale 1ns/1ps
module low_power_logger_sequencer
  import logger_seq_pkg::*;
#(
  parameter longint unsigned MINUTE_CYCLES_P = MINUTE_CYCLES
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                ext_irq_i,
  input  wire logic                button_i,
  input  wire logic                conv_done_i,
  input  wire logic [SAMPLE_W-1:0] conv_ch0_i,
  input  wire logic [SAMPLE_W-1:0] conv_ch1_i,
  input  wire logic [SAMPLE_W-1:0] threshold_i,
  input  wire logic                tx_done_i,
  output logic                     conv_start_o,
  output logic                     buf_wr_o,
  output logic [ADDR_W-1:0]        buf_addr_o,
  output logic [SAMPLE_W-1:0]      buf_data_o,
  output logic                     level_irq_o,
  output logic                     tx_start_o,
  output logic [1:0]               tx_cause_o,
  output logic [1:0]               mode_o,
  output logic                     cpu_wake_o
);

  function automatic logic [1:0] mode_of(input seq_state_t s);
    case (s)
      ST_STANDBY: mode_of = MODE_STANDBY;
      ST_CONV,
      ST_WRITE,
      ST_CMP:     mode_of = MODE_SNOOZE;
      default:    mode_of = MODE_NORMAL;
    endcase
  endfunction

  seq_state_t state_reg;
  seq_state_t state_next;

  logic                minute_tick;
  logic                snooze_tick;
  logic                irq_meta_reg;
  logic                irq_sync_reg;
  logic                irq_prev_reg;
  logic                btn_meta_reg;
  logic                btn_sync_reg;
  logic                btn_prev_reg;
  logic                snz_pend_reg;
  logic                alarm_pend_reg;
  logic                irq_pend_reg;
  logic                btn_pend_reg;
  logic                alarm_cause_reg;
  logic                alarm_armed_reg;
  logic [ALARM_W-1:0]  alarm_cnt_reg;
  logic [SAMPLE_W-1:0] samp1_reg;

  logic                conv_start_next;
  logic                wr_next;
  logic [ADDR_W-1:0]   addr_next;
  logic [SAMPLE_W-1:0] data_next;
  logic                irq_next;
  logic                tx_start_next;
  logic [1:0]          cause_next;
  logic                go_tx;

  interval_timer #(
    .STAGE1_CYCLES (MINUTE_CYCLES_P)
  ) u_interval_timer (
    .core_clk_i    (core_clk_i),
    .rst_b_i       (rst_b_i),
    .stage1_tick_o (minute_tick),
    .stage2_tick_o (snooze_tick)
  );

  // pins are synchronised; edge detectors look only at the second stage and its delayed copy
  wire irq_edge    = irq_sync_reg & ~irq_prev_reg;
  wire btn_edge    = btn_sync_reg & ~btn_prev_reg;
  wire alarm_fire  = minute_tick & alarm_armed_reg & (alarm_cnt_reg == '0);
  wire esc_any     = alarm_pend_reg | irq_pend_reg | btn_pend_reg;
  wire level_hit   = (samp1_reg >= threshold_i);
  wire conv_enter  = (state_next == ST_CONV) && (state_reg == ST_STANDBY);
  wire rearm       = (state_reg == ST_DONE) && alarm_cause_reg;
  wire [1:0] esc_cause = alarm_pend_reg ? CAUSE_ALARM : irq_pend_reg ? CAUSE_IRQ : CAUSE_BUTTON;

  always_comb begin
    state_next      = state_reg;
    conv_start_next = 1'b0;
    wr_next         = 1'b0;
    addr_next       = buf_addr_o;
    data_next       = buf_data_o;
    irq_next        = 1'b0;
    tx_start_next   = 1'b0;
    cause_next      = tx_cause_o;
    go_tx           = 1'b0;
    case (state_reg)
      ST_STANDBY: begin
        if (esc_any) begin
          state_next    = ST_TX;
          tx_start_next = 1'b1;
          cause_next    = esc_cause;
          go_tx         = 1'b1;
        end else if (snz_pend_reg) begin
          state_next      = ST_CONV;
          conv_start_next = 1'b1;
        end
      end
      ST_CONV: begin
        if (conv_done_i) begin
          state_next = ST_WRITE;
          wr_next    = 1'b1;
          data_next  = conv_ch0_i;
        end
      end
      ST_WRITE: begin
        state_next = ST_CMP;
        wr_next    = 1'b1;
        data_next  = samp1_reg;
        addr_next  = buf_addr_o + 1'b1;
      end
      ST_CMP: begin
        addr_next = buf_addr_o + 1'b1;
        if (level_hit) begin
          state_next    = ST_TX;
          irq_next      = 1'b1;
          tx_start_next = 1'b1;
          cause_next    = CAUSE_LEVEL;
          go_tx         = 1'b1;
        end else if (esc_any) begin
          state_next    = ST_TX;
          tx_start_next = 1'b1;
          cause_next    = esc_cause;
          go_tx         = 1'b1;
        end else begin
          state_next = ST_STANDBY;
        end
      end
      ST_TX: begin
        if (tx_done_i) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE:  state_next = ST_STANDBY;
      default:  state_next = ST_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
      irq_prev_reg <= 1'b0;
      btn_meta_reg <= 1'b0;
      btn_sync_reg <= 1'b0;
      btn_prev_reg <= 1'b0;
    end else begin
      irq_meta_reg <= ext_irq_i;
      irq_sync_reg <= irq_meta_reg;
      irq_prev_reg <= irq_sync_reg;
      btn_meta_reg <= button_i;
      btn_sync_reg <= btn_meta_reg;
      btn_prev_reg <= btn_sync_reg;
    end
  end

  // a new event in the cycle its flag is consumed is kept: set wins
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      snz_pend_reg    <= 1'b0;
      alarm_pend_reg  <= 1'b0;
      irq_pend_reg    <= 1'b0;
      btn_pend_reg    <= 1'b0;
      alarm_cause_reg <= 1'b0;
    end else begin
      snz_pend_reg   <= snooze_tick | (snz_pend_reg & ~conv_enter);
      alarm_pend_reg <= alarm_fire | (alarm_pend_reg & ~go_tx);
      irq_pend_reg   <= irq_edge | (irq_pend_reg & ~go_tx);
      btn_pend_reg   <= btn_edge | (btn_pend_reg & ~go_tx);
      if (go_tx) begin
        alarm_cause_reg <= alarm_pend_reg;
      end
    end
  end

  // the alarm fires once, then stays quiet until the alarm-caused pass re-arms it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_cnt_reg   <= ALARM_RELOAD;
      alarm_armed_reg <= 1'b1;
    end else if (rearm) begin
      alarm_cnt_reg   <= ALARM_RELOAD;
      alarm_armed_reg <= 1'b1;
    end else if (alarm_fire) begin
      alarm_armed_reg <= 1'b0;
    end else if (minute_tick && alarm_armed_reg) begin
      alarm_cnt_reg   <= alarm_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= ST_STANDBY;
      samp1_reg    <= SAMPLE_RST;
      conv_start_o <= 1'b0;
      buf_wr_o     <= 1'b0;
      buf_addr_o   <= ADDR_RST;
      buf_data_o   <= SAMPLE_RST;
      level_irq_o  <= 1'b0;
      tx_start_o   <= 1'b0;
      tx_cause_o   <= CAUSE_ALARM;
      mode_o       <= MODE_STANDBY;
      cpu_wake_o   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      if (state_reg == ST_CONV && conv_done_i) begin
        samp1_reg <= conv_ch1_i;
      end
      conv_start_o <= conv_start_next;
      buf_wr_o     <= wr_next;
      buf_addr_o   <= addr_next;
      buf_data_o   <= data_next;
      level_irq_o  <= irq_next;
      tx_start_o   <= tx_start_next;
      tx_cause_o   <= cause_next;
      mode_o       <= mode_of(state_next);
      cpu_wake_o   <= (mode_of(state_next) == MODE_NORMAL);
    end
  end

  sequence s_two_writes;
    buf_wr_o ##1 buf_wr_o;
  endsequence

  sequence s_to_normal_tx;
    tx_start_o && (mode_o == MODE_NORMAL) && cpu_wake_o;
  endsequence

  property p_snooze_start;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_STANDBY) && snz_pend_reg && !esc_any |=> conv_start_o && (mode_o == MODE_SNOOZE);
  endproperty
  a_snooze_start: assert property (p_snooze_start) else $error("snooze not entered on timer request");

  property p_store_pass;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_CONV) && conv_done_i |=> s_two_writes ##1 !buf_wr_o;
  endproperty
  a_store_pass: assert property (p_store_pass) else $error("conversion results not stored");

  property p_addr_advance;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_two_writes |-> buf_addr_o == ADDR_W'($past(buf_addr_o) + 1'b1);
  endproperty
  a_addr_advance: assert property (p_addr_advance) else $error("buffer position did not advance");

  property p_level_escalate;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_CMP) && level_hit |=> s_to_normal_tx and (level_irq_o && (tx_cause_o == CAUSE_LEVEL));
  endproperty
  a_level_escalate: assert property (p_level_escalate) else $error("level hit did not escalate");

  property p_no_false_level;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      level_irq_o |-> $past(samp1_reg) >= $past(threshold_i);
  endproperty
  a_no_false_level: assert property (p_no_false_level) else $error("level interrupt below threshold");

  property p_back_to_standby;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_CMP) && !level_hit && !esc_any |=> (mode_o == MODE_STANDBY) && !tx_start_o;
  endproperty
  a_back_to_standby: assert property (p_back_to_standby) else $error("snooze did not return to standby");

  property p_snooze_asleep;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (mode_o == MODE_SNOOZE) |-> !cpu_wake_o && !tx_start_o;
  endproperty
  a_snooze_asleep: assert property (p_snooze_asleep) else $error("processor woken in snooze");

  property p_escalate;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_STANDBY) && esc_any |=> s_to_normal_tx;
  endproperty
  a_escalate: assert property (p_escalate) else $error("wake event did not start transmission");

  property p_done_returns;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (state_reg == ST_TX) && tx_done_i |=> (mode_o == MODE_NORMAL) ##1 (mode_o == MODE_STANDBY) && !cpu_wake_o;
  endproperty
  a_done_returns: assert property (p_done_returns) else $error("no return to low power after send");

  property p_rearm;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      rearm |=> alarm_armed_reg && (alarm_cnt_reg == ALARM_RELOAD) && (mode_o == MODE_STANDBY);
  endproperty
  a_rearm: assert property (p_rearm) else $error("alarm not re-armed");

endmodule

// ---- inc/logger_seq_pkg.sv ----
// constants, states and encodings shared by the low-power logger sequencer files
package logger_seq_pkg;

  // clock and time base
  localparam longint unsigned CLK_HZ            = 64'd100_000_000;
  localparam longint unsigned MINUTE_S          = 64'd60;
  localparam longint unsigned MINUTE_CYCLES     = MINUTE_S * CLK_HZ;
  localparam int              SNOOZE_PERIOD_MIN = 30;
  localparam int              ALARM_PERIOD_H    = 24;

  // widths
  localparam int PRESC_W  = 40;
  localparam int STAGE2_W = 8;
  localparam int ALARM_W  = 16;
  localparam int SAMPLE_W = 12;
  localparam int ADDR_W   = 8;

  // counter reload and reset values
  localparam logic [STAGE2_W-1:0] STAGE2_RELOAD = STAGE2_W'(SNOOZE_PERIOD_MIN - 1);
  localparam logic [ALARM_W-1:0]  ALARM_RELOAD  = ALARM_W'(ALARM_PERIOD_H * 60 - 1);
  localparam logic [ADDR_W-1:0]   ADDR_RST      = 8'h00;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST    = 12'h000;

  // power modes shown on mode_o
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_SNOOZE  = 2'h1;
  localparam logic [1:0] MODE_NORMAL  = 2'h2;

  // reason for a transmission shown on tx_cause_o
  localparam logic [1:0] CAUSE_ALARM  = 2'h0;
  localparam logic [1:0] CAUSE_IRQ    = 2'h1;
  localparam logic [1:0] CAUSE_LEVEL  = 2'h2;
  localparam logic [1:0] CAUSE_BUTTON = 2'h3;

  // sequencer states, gray coded along standby-convert-write-compare-transmit-done
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_CONV    = 3'h1,
    ST_WRITE   = 3'h3,
    ST_CMP     = 3'h2,
    ST_TX      = 3'h6,
    ST_DONE    = 3'h7
  } seq_state_t;

endpackage

// ---- hdl/interval_timer.sv ----
// two-stage interval timer: minute prescaler feeding a snooze-period counter
`timescale 1ns/1ps
module interval_timer
  import logger_seq_pkg::*;
#(
  parameter longint unsigned STAGE1_CYCLES = MINUTE_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  output logic      stage1_tick_o,
  output logic      stage2_tick_o
);

  localparam logic [PRESC_W-1:0] STAGE1_RELOAD = PRESC_W'(STAGE1_CYCLES - 64'd1);

  logic [PRESC_W-1:0]  presc_reg;
  logic [STAGE2_W-1:0] stage2_reg;

  wire stage1_uf = (presc_reg == '0);
  wire stage2_uf = stage1_uf && (stage2_reg == '0);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      presc_reg     <= STAGE1_RELOAD;
      stage2_reg    <= STAGE2_RELOAD;
      stage1_tick_o <= 1'b0;
      stage2_tick_o <= 1'b0;
    end else begin
      presc_reg     <= stage1_uf ? STAGE1_RELOAD : presc_reg - 1'b1;
      // the second stage only moves on first-stage underflows
      if (stage1_uf) begin
        stage2_reg <= (stage2_reg == '0) ? STAGE2_RELOAD : stage2_reg - 1'b1;
      end
      stage1_tick_o <= stage1_uf;
      stage2_tick_o <= stage2_uf;
    end
  end

  property p_stage2_on_stage1;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      stage2_tick_o |-> stage1_tick_o && (stage2_reg == STAGE2_RELOAD);
  endproperty
  a_stage2_on_stage1: assert property (p_stage2_on_stage1) else $error("stage2 tick without full count");

endmodule

// ---- sim/logger_link_partner.sv ----
// behavioural converter and serial terminal that face the logger sequencer
`timescale 1ns/1ps
module logger_link_partner
  import logger_seq_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                conv_start_i,
  input  wire logic                tx_start_i,
  input  wire logic [SAMPLE_W-1:0] ch0_val_i,
  input  wire logic [SAMPLE_W-1:0] ch1_val_i,
  input  wire logic [7:0]          conv_delay_i,
  input  wire logic [7:0]          tx_delay_i,
  output logic                     conv_done_o,
  output logic [SAMPLE_W-1:0]      conv_ch0_o,
  output logic [SAMPLE_W-1:0]      conv_ch1_o,
  output logic                     tx_done_o
);
  initial begin
    conv_done_o = 1'b0;
    conv_ch0_o  = 12'h000;
    conv_ch1_o  = 12'h000;
    tx_done_o   = 1'b0;
  end

  // one result pair per start; after each done cycle the lines carry inverted junk, not stale data
  always begin
    @(negedge core_clk_i);
    if (conv_start_i === 1'b1) begin
      repeat (conv_delay_i) @(negedge core_clk_i);
      conv_done_o = 1'b1;
      conv_ch0_o  = ch0_val_i;
      conv_ch1_o  = ch1_val_i;
      @(negedge core_clk_i);
      conv_done_o = 1'b0;
      conv_ch0_o  = ~conv_ch0_o;
      conv_ch1_o  = ~conv_ch1_o;
    end
  end

  // the terminal reports one completed transfer per start, after a chosen delay
  always begin
    @(negedge core_clk_i);
    if (tx_start_i === 1'b1) begin
      repeat (tx_delay_i) @(negedge core_clk_i);
      tx_done_o = 1'b1;
      @(negedge core_clk_i);
      tx_done_o = 1'b0;
    end
  end
endmodule

// ---- sim/low_power_logger_sequencer_tb_top.sv ----
// self-checking bench for the low-power logger sequencer with its converter and terminal models
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module low_power_logger_sequencer_tb_top
  import logger_seq_pkg::*;
;
  logic                core_clk_i;
  logic                rst_b_i;
  logic                ext_irq_i;
  logic                button_i;
  logic                conv_done_i;
  logic [SAMPLE_W-1:0] conv_ch0_i;
  logic [SAMPLE_W-1:0] conv_ch1_i;
  logic [SAMPLE_W-1:0] threshold_i;
  logic                tx_done_i;
  logic                conv_start_o;
  logic                buf_wr_o;
  logic [ADDR_W-1:0]   buf_addr_o;
  logic [SAMPLE_W-1:0] buf_data_o;
  logic                level_irq_o;
  logic                tx_start_o;
  logic [1:0]          tx_cause_o;
  logic [1:0]          mode_o;
  logic                cpu_wake_o;
  logic [SAMPLE_W-1:0] ch0_val;
  logic [SAMPLE_W-1:0] ch1_val;
  logic [7:0]          conv_delay;
  logic [7:0]          tx_delay;
  int                  fail_count = 0;
  int                  checked = 0;
  int                  passes = 0;

  // a minute of four cycles: snooze every 120 cycles, alarm every 5760
  low_power_logger_sequencer #(.MINUTE_CYCLES_P(64'd4)) dut_u (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ext_irq_i(ext_irq_i), .button_i(button_i),
    .conv_done_i(conv_done_i), .conv_ch0_i(conv_ch0_i), .conv_ch1_i(conv_ch1_i), .threshold_i(threshold_i),
    .tx_done_i(tx_done_i), .conv_start_o(conv_start_o), .buf_wr_o(buf_wr_o), .buf_addr_o(buf_addr_o),
    .buf_data_o(buf_data_o), .level_irq_o(level_irq_o), .tx_start_o(tx_start_o), .tx_cause_o(tx_cause_o),
    .mode_o(mode_o), .cpu_wake_o(cpu_wake_o));

  logger_link_partner link_u (
    .core_clk_i(core_clk_i), .conv_start_i(conv_start_o), .tx_start_i(tx_start_o), .ch0_val_i(ch0_val),
    .ch1_val_i(ch1_val), .conv_delay_i(conv_delay), .tx_delay_i(tx_delay), .conv_done_o(conv_done_i),
    .conv_ch0_o(conv_ch0_i), .conv_ch1_o(conv_ch1_i), .tx_done_o(tx_done_i));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // completed passes, counted from the converter side, give the expected write position
  always @(posedge core_clk_i) begin
    if (conv_done_i === 1'b1) begin
      passes <= passes + 1;
    end
  end

  task automatic give_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: hit = (conv_start_o === 1'b1);
      1: hit = (tx_start_o === 1'b1);
      2: hit = (mode_o === MODE_STANDBY);
      default: hit = (buf_wr_o === 1'b1);
    endcase
  endfunction

  // called on a falling edge; a bound that runs out ends the run
  task automatic wait_on(input int sel, input int bound);
    int n;
    n = 0;
    while (!hit(sel) && n < bound) begin
      @(negedge core_clk_i);
      n++;
    end
    if (!hit(sel)) begin
      fail_count++;
      $display("MISMATCH wait_%0d expected 1 seen 0", sel);
      give_verdict();
    end
  endtask

  task automatic snooze_quiet();
    logic [ADDR_W-1:0] a;
    time               t0;
    bit                esc;
    int                n;
    esc = 1'b0;
    n   = 0;
    wait_on(0, 200);
    t0 = $time;
    a  = ADDR_W'(2 * passes);
    `CHK("mode_snooze", MODE_SNOOZE, mode_o)
    `CHK("cpu_asleep", 1'b0, cpu_wake_o)
    wait_on(3, 20);
    `CHK("addr_ch0", a, buf_addr_o)
    `CHK("data_ch0", ch0_val, buf_data_o)
    @(negedge core_clk_i);
    `CHK("wr_ch1", 1'b1, buf_wr_o)
    `CHK("addr_ch1", ADDR_W'(a + 8'h01), buf_addr_o)
    `CHK("data_ch1", ch1_val, buf_data_o)
    while (mode_o === MODE_SNOOZE && n < 20) begin
      esc = esc | (level_irq_o === 1'b1) | (tx_start_o === 1'b1);
      @(negedge core_clk_i);
      n++;
    end
    if (mode_o === MODE_SNOOZE) begin
      fail_count++;
      $display("MISMATCH snooze_exit expected 1 seen 0");
      give_verdict();
    end
    `CHK("no_escalation", 1'b0, esc)
    `CHK("back_standby", MODE_STANDBY, mode_o)
    wait_on(0, 200);
    `CHK("snooze_period", 64'd1200, 64'($time - t0))
  endtask

  // result equal to the threshold is the lowest one that escalates
  // conv delay stays put: the converter model reads it on the very edge this task starts at
  task automatic level_escalate();
    ch1_val    = threshold_i;
    tx_delay   = 8'h00;
    wait_on(0, 200);
    wait_on(1, 30);
    `CHK("level_irq", 1'b1, level_irq_o)
    `CHK("cause_level", CAUSE_LEVEL, tx_cause_o)
    `CHK("mode_normal", MODE_NORMAL, mode_o)
    `CHK("cpu_awake", 1'b1, cpu_wake_o)
    wait_on(2, 40);
    `CHK("cpu_sleeps", 1'b0, cpu_wake_o)
    ch1_val    = 12'h7FF;
    tx_delay   = 8'h09;
  endtask

  task automatic pin_wake(input bit use_button);
    if (use_button) begin
      button_i = 1'b1;
    end else begin
      ext_irq_i = 1'b1;
    end
    repeat (4) @(negedge core_clk_i);
    button_i  = 1'b0;
    ext_irq_i = 1'b0;
    wait_on(1, 40);
    `CHK("pin_cause", use_button ? CAUSE_BUTTON : CAUSE_IRQ, tx_cause_o)
    `CHK("pin_mode", MODE_NORMAL, mode_o)
    wait_on(2, 40);
    `CHK("pin_return", 1'b0, cpu_wake_o)
  endtask

  // the second alarm must come a full day of minute ticks after the re-arm
  task automatic alarm_cycle();
    time t1;
    wait_on(1, 6000);
    `CHK("cause_alarm", CAUSE_ALARM, tx_cause_o)
    wait_on(2, 40);
    t1 = $time;
    `CHK("alarm_return", MODE_STANDBY, mode_o)
    @(negedge core_clk_i);
    wait_on(1, 6000);
    `CHK("cause_rearmed", CAUSE_ALARM, tx_cause_o)
    `CHK("alarm_gap", 1'b1, ($time - t1 >= 57500) && ($time - t1 <= 57700))
    wait_on(2, 40);
  endtask

  initial begin
    rst_b_i     = 1'b0;
    ext_irq_i   = 1'b0;
    button_i    = 1'b0;
    threshold_i = 12'h800;
    ch0_val     = 12'h5A5;
    ch1_val     = 12'h7FF;
    conv_delay  = 8'h06;
    tx_delay    = 8'h09;
    repeat (2) @(negedge core_clk_i);
    `CHK("rst_mode", MODE_STANDBY, mode_o)
    `CHK("rst_addr", ADDR_RST, buf_addr_o)
    rst_b_i = 1'b1;
    snooze_quiet();
    level_escalate();
    pin_wake(1'b0);
    pin_wake(1'b1);
    alarm_cycle();
    give_verdict();
  end
endmodule
